/* hw/pbsp_port.sv */
/*
 Synchronous control port and storage of a pipelined burst static memory.
 Assumes the controller drives strobes, selects, address, write controls and
 write data on mclk; output enable, sleep and the order strap are asynchronous.
*/
module pbsp_port
    import pbsp_pkg::*;
#(
    parameter int unsigned ADDR_W = PBSP_ADDR_W,
    parameter bit HAS_THIRD_SELECT = 1'b1
) (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic [ADDR_W-1:0] address,
    input wire logic processor_addr_strobe_n,
    input wire logic controller_addr_strobe_n,
    input wire logic burst_advance_n,
    input wire logic all_bytes_write_n,
    input wire logic lane_write_enable_n,
    input wire logic [PBSP_LANES-1:0] lane_write_select_n,
    input wire logic chip_select_first_n,
    input wire logic chip_select_second,
    input wire logic chip_select_third_n,
    input wire logic output_enable_n,
    input wire logic sleep_request,
    input wire logic burst_order_strap,
    input wire logic [PBSP_DATA_W-1:0] dq_in,
    output logic [PBSP_DATA_W-1:0] dq_out,
    output logic dq_oe,
    input wire logic [PBSP_LANES-1:0] data_parity_lines_in,
    output logic [PBSP_LANES-1:0] data_parity_lines_out,
    output logic data_parity_lines_oe,
    output logic sleeping
);
    localparam int unsigned DEPTH = 1 << ADDR_W;

    pbsp_cycle_e cycle_reg, cycle_next;
    logic [ADDR_W-1:0] addr_reg, addr_next;
    pbsp_word_t mem_reg [DEPTH], mem_next [DEPTH];
    pbsp_word_t out_data_reg, out_data_next;
    logic drive_reg, drive_next;
    logic hold_reg, hold_next;
    logic sleep_s1_reg, sleep_reg;
    logic strap_s1_reg, strap_s2_reg;
    logic order_reg, order_next;
    logic strap_taken_reg, strap_taken_next;
    logic [1:0] strap_age_reg, strap_age_next;

    logic third_active, selected, proc_take, ctrl_take, load, load_sel;
    logic active, cont, any_lane, write_now, read_now;
    pbsp_word_t wr_mask, wr_data, old_word;
    pbsp_burst_t cur_bits;
    logic [ADDR_W-1:0] acc_addr;

    // Sleep and strap are asynchronous pins: two flops before use.
    // Reset value of sleep is deasserted, matching an open pin.
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            sleep_s1_reg <= PBSP_SYNC_RST;
            sleep_reg <= PBSP_SYNC_RST;
            strap_s1_reg <= PBSP_ORDER_RST;
            strap_s2_reg <= PBSP_ORDER_RST;
        end else begin
            sleep_s1_reg <= sleep_request;
            sleep_reg <= sleep_s1_reg;
            strap_s1_reg <= burst_order_strap;
            strap_s2_reg <= strap_s1_reg;
        end
    end

    // Strap is caught once, after the synchroniser holds the pin's level
    // rather than its reset value; later wiggles are ignored
    always_comb begin
        order_next = order_reg;
        strap_taken_next = strap_taken_reg;
        strap_age_next = strap_age_reg;
        if (!strap_taken_reg) begin
            strap_age_next = strap_age_reg + 2'h1;
            if (strap_age_reg == PBSP_STRAP_WAIT) begin
                order_next = strap_s2_reg;
                strap_taken_next = 1'b1;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            order_reg <= PBSP_ORDER_RST;
            strap_taken_reg <= 1'b0;
            strap_age_reg <= 2'h0;
        end else begin
            order_reg <= order_next;
            strap_taken_reg <= strap_taken_next;
            strap_age_reg <= strap_age_next;
        end
    end

    assign third_active = HAS_THIRD_SELECT ? ~chip_select_third_n : 1'b1;
    assign selected = ~chip_select_first_n & chip_select_second & third_active;
    assign proc_take = ~processor_addr_strobe_n & ~chip_select_first_n & ~sleep_reg;
    assign ctrl_take = ~controller_addr_strobe_n & ~proc_take & ~sleep_reg;
    assign load = proc_take | ctrl_take;
    assign load_sel = load & selected;
    assign active = (cycle_reg == PBSP_READ) || (cycle_reg == PBSP_WRITE);
    // Selects are not looked at once the burst runs on its own
    assign cont = ~load & active & ~sleep_reg;

    pbsp_burst_ctr u_burst (
        .mclk(mclk),
        .rstn(rstn),
        .load(load_sel),
        .advance(cont & ~burst_advance_n),
        .interleave(order_reg),
        .start_bits(address[PBSP_BURST_LSB +: PBSP_BURST_W]),
        .cur_bits(cur_bits)
    );

    assign addr_next = load_sel ? address : addr_reg;
    assign acc_addr = {addr_next[ADDR_W-1:PBSP_BURST_W], cur_bits};

    // Processor-strobe cycles never write (reads when selected, else deselects); writes follow in later cycles
    assign any_lane = ~lane_write_enable_n & ~(&lane_write_select_n);
    assign write_now = ((ctrl_take & selected) | cont) & (~all_bytes_write_n | any_lane);
    assign wr_mask = ~all_bytes_write_n ? {PBSP_WORD_W{1'b1}}
                                        : pbsp_lane_mask(~lane_write_select_n);
    assign wr_data = {data_parity_lines_in, dq_in};
    assign read_now = (load_sel | cont) & ~write_now;
    assign old_word = mem_reg[acc_addr];

    always_comb begin
        cycle_next = cycle_reg;
        if (sleep_reg) begin
            cycle_next = PBSP_SLEEP;
        end else if (load) begin
            cycle_next = !selected ? PBSP_IDLE : (write_now ? PBSP_WRITE : PBSP_READ);
        end else if (cont) begin
            cycle_next = write_now ? PBSP_WRITE : PBSP_READ;
        end else begin
            case (cycle_reg)
                PBSP_SLEEP: cycle_next = PBSP_IDLE;
                default: cycle_next = cycle_reg;
            endcase
        end
    end

    always_comb begin
        mem_next = mem_reg;
        if (write_now) begin
            mem_next[acc_addr] = (old_word & ~wr_mask) | (wr_data & wr_mask);
        end
    end

    // Output stage: data of this edge's read shows after the edge.
    // On a deselect the lines keep driving one extra cycle so a second
    // bank can take over without a gap or a clash.
    always_comb begin
        out_data_next = out_data_reg;
        drive_next = 1'b0;
        hold_next = 1'b0;
        if (read_now) begin
            out_data_next = old_word;
            drive_next = 1'b1;
        end else if (drive_reg & ~hold_reg & ~write_now & ~sleep_reg) begin
            drive_next = 1'b1;
            hold_next = 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            cycle_reg <= PBSP_IDLE;
            addr_reg <= '0;
            out_data_reg <= '0;
            drive_reg <= 1'b0;
            hold_reg <= 1'b0;
        end else begin
            cycle_reg <= cycle_next;
            addr_reg <= addr_next;
            out_data_reg <= out_data_next;
            drive_reg <= drive_next;
            hold_reg <= hold_next;
        end
    end

    // Contents survive reset and sleep
    always_ff @(posedge mclk) begin
        mem_reg <= mem_next;
    end

    // Output enable is asynchronous by nature and gates the drivers directly.
    // Drive stays off in the first clock of a read out of deselect, whatever
    // output enable does, unless that clock is the hold cycle right after the deselect,
    // since drive_reg otherwise only rises after the first read edge.
    assign dq_oe = drive_reg & ~output_enable_n;
    assign data_parity_lines_oe = drive_reg & ~output_enable_n;
    assign dq_out = out_data_reg[PBSP_DATA_W-1:0];
    assign data_parity_lines_out = out_data_reg[PBSP_WORD_W-1:PBSP_DATA_W];
    assign sleeping = (cycle_reg == PBSP_SLEEP);

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rstn);

    AST_ADDR_CAPTURE: assert property (load_sel |=> addr_reg == $past(address))
        else $error("address not captured on selected strobe");
    AST_DESELECT: assert property (load && !selected |=> cycle_reg == PBSP_IDLE)
        else $error("device stayed selected with selects inactive");
    AST_PROC_WINS: assert property (proc_take && !controller_addr_strobe_n
        |-> !write_now)
        else $error("write taken while processor strobe had priority");
    AST_PROC_BLOCKED: assert property (!processor_addr_strobe_n && chip_select_first_n
        && controller_addr_strobe_n && !sleep_reg && !active |=> cycle_reg == PBSP_IDLE)
        else $error("processor strobe acted with first select high");
    AST_SEL_IGNORED: assert property (cont |=> cycle_reg != PBSP_IDLE)
        else $error("burst cycle dropped on chip select change");
    AST_ADVANCE: assert property (cont && !burst_advance_n && $past(read_now | write_now)
        |-> cur_bits != $past(cur_bits))
        else $error("advance did not step burst address");
    AST_HOLD: assert property (cont && burst_advance_n && $past(read_now | write_now)
        |-> cur_bits == $past(cur_bits))
        else $error("burst address moved without advance");
    AST_GLOBAL_WRITE: assert property (write_now && !all_bytes_write_n
        |=> mem_reg[$past(acc_addr)] == $past(wr_data))
        else $error("global write missed a lane");
    AST_NO_LANE_WRITE: assert property (cont && all_bytes_write_n && lane_write_enable_n
        |=> mem_reg[$past(acc_addr)] == $past(old_word))
        else $error("lane selects wrote without lane enable");
    AST_PIPELINE: assert property (read_now |=> dq_out == $past(old_word[PBSP_DATA_W-1:0])
        && drive_reg)
        else $error("read data not presented one cycle later");
    AST_OE_RELEASE: assert property (output_enable_n |-> !dq_oe && !data_parity_lines_oe)
        else $error("lines driven with output enable high");
    AST_FIRST_READ: assert property (!active && !drive_reg && load_sel |-> !dq_oe)
        else $error("lines driven in first read clock after deselect");
    AST_SLEEP: assert property (sleep_reg
        |-> !read_now && !write_now ##1 !active && !drive_reg)
        else $error("device active while asleep");
    AST_SLEEP_ENTRY: assert property (sleep_reg |=> sleeping)
        else $error("sleep request did not reach sleep state");
    AST_STRAP_TAKEN: assert property (!strap_taken_reg && strap_age_reg == PBSP_STRAP_WAIT
        |=> order_reg == $past(strap_s2_reg) && strap_taken_reg)
        else $error("burst order not taken from strap");
    AST_STRAP_STATIC: assert property (strap_taken_reg |=> $stable(order_reg))
        else $error("burst order changed after strap was taken");
    AST_THIRD_SELECT: assert property (!chip_select_first_n && chip_select_second
        && (!HAS_THIRD_SELECT || !chip_select_third_n) |-> selected)
        else $error("device not selected with selects active");
    AST_CTRL_LOAD: assert property (ctrl_take && selected |=> addr_reg == $past(address)
        && active)
        else $error("controller strobe did not load address");
    AST_PROC_READ: assert property (proc_take && selected |-> read_now)
        else $error("processor strobe did not start a read");
    AST_OUT_STANDS: assert property (!read_now |=> $stable(dq_out))
        else $error("read data changed without a read");
    AST_DESELECT_HOLD: assert property (drive_reg && !hold_reg && load && !selected
        |=> drive_reg && hold_reg)
        else $error("drivers not held one cycle after deselect");

    COV_BURST4: cover property (load_sel && read_now ##1 (cont && !burst_advance_n)[*3]);
    COV_LANE_WRITE: cover property (write_now && all_bytes_write_n);
    COV_DESELECT_HOLD: cover property (drive_reg && load && !selected ##1 drive_reg);
    COV_SLEEP: cover property (sleep_reg ##1 sleeping);
    COV_LINEAR: cover property (!order_reg && cont && !burst_advance_n);
endmodule

/* hw/pbsp_pkg.sv */
/*
 Constants, types and helper functions of the pipelined burst memory port.
 Assumes one clock for all synchronous pins and a synchronous active-low reset.
*/
// Behaviour
// - Capture address on strobe with chip selected
// - Low two address bits seed burst counter
// - Lane selects act only with lane enable
// - Global write writes every lane
// - Advance low steps burst counter
// - Selected when first, third low, second high
// - Chip selects ignored during advanced burst cycles
// - Missing third select counts as active
// - Output enable low drives, high releases lines
// - First read after deselect stays undriven unless its strobe comes in the hold cycle right after the deselect
// - Processor strobe loads address and counter
// - Controller strobe loads address and counter
// - Both strobes low: processor strobe wins
// - Processor strobe ignored while first select high
// - Sleep idles device, keeps contents
// - Strap low linear, high interleaved order
// - Read data appears one cycle later
package pbsp_pkg;
    localparam int unsigned PBSP_LANES = 4;
    localparam int unsigned PBSP_BYTE_W = 8;
    localparam int unsigned PBSP_DATA_W = PBSP_LANES * PBSP_BYTE_W;
    localparam int unsigned PBSP_WORD_W = PBSP_DATA_W + PBSP_LANES;
    localparam int unsigned PBSP_ADDR_W = 19;
    localparam int unsigned PBSP_BURST_W = 2;
    localparam int unsigned PBSP_BURST_LSB = 0;
    localparam logic [1:0] PBSP_BURST_RST = 2'h0;
    localparam logic PBSP_ORDER_RST = 1'h1;
    localparam logic PBSP_SYNC_RST = 1'h0;
    localparam logic [1:0] PBSP_STRAP_WAIT = 2'h2;

    typedef logic [PBSP_BURST_W-1:0] pbsp_burst_t;
    typedef logic [PBSP_WORD_W-1:0] pbsp_word_t;

    // Gray along idle -> read -> write; sleep is the fourth code
    typedef enum logic [1:0] {
        PBSP_IDLE = 2'h0,
        PBSP_READ = 2'h1,
        PBSP_WRITE = 2'h3,
        PBSP_SLEEP = 2'h2
    } pbsp_cycle_e;

    function automatic pbsp_burst_t pbsp_burst_addr(input pbsp_burst_t start,
                                                    input pbsp_burst_t count,
                                                    input logic interleave);
        pbsp_burst_t sum;
        sum = start + count;
        return interleave ? (start ^ count) : sum;
    endfunction

    // Data lanes in the low bits, one parity bit per lane above them
    function automatic pbsp_word_t pbsp_lane_mask(input logic [PBSP_LANES-1:0] lanes);
        pbsp_word_t m;
        m = '0;
        for (int i = 0; i < PBSP_LANES; i++) begin
            m[i*PBSP_BYTE_W +: PBSP_BYTE_W] = {PBSP_BYTE_W{lanes[i]}};
            m[PBSP_DATA_W + i] = lanes[i];
        end
        return m;
    endfunction
endpackage

/* hw/pbsp_burst_ctr.sv */
/*
 Two-bit wrapping burst counter of the memory port.
 Assumes load and advance are never asked in the same cycle by the caller.
*/
module pbsp_burst_ctr
    import pbsp_pkg::*;
(
    input wire logic mclk,
    input wire logic rstn,
    input wire logic load,
    input wire logic advance,
    input wire logic interleave,
    input wire pbsp_burst_t start_bits,
    output pbsp_burst_t cur_bits
);
    pbsp_burst_t start_reg, start_next;
    pbsp_burst_t count_reg, count_next;

    always_comb begin
        start_next = start_reg;
        count_next = count_reg;
        if (load) begin
            start_next = start_bits;
            count_next = PBSP_BURST_RST;
        end else if (advance) begin
            count_next = count_reg + 2'h1;
        end
    end

    // Address of the access taken at this edge
    assign cur_bits = pbsp_burst_addr(start_next, count_next, interleave);

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            start_reg <= PBSP_BURST_RST;
            count_reg <= PBSP_BURST_RST;
        end else begin
            start_reg <= start_next;
            count_reg <= count_next;
        end
    end

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rstn);

    AST_CTR_WRAP: assert property (advance ##1 advance ##1 advance ##1 advance
        |-> cur_bits == $past(cur_bits, 4))
        else $error("burst did not wrap after four steps");
    AST_CTR_SEED: assert property (load |-> cur_bits == start_bits)
        else $error("burst counter not seeded from start bits");
endmodule

/* bench/pbsp_ctrl_model.sv */
/*
 Behavioural processor or cache controller driving the memory port's bus.
 Assumes the port samples all synchronous pins on the rising edge of mclk.
*/
module pbsp_ctrl_model
    import pbsp_pkg::*;
#(
    parameter int AW = 4
) (
    input wire logic mclk,
    output logic [AW-1:0] address,
    output logic processor_addr_strobe_n,
    output logic controller_addr_strobe_n,
    output logic burst_advance_n,
    output logic all_bytes_write_n,
    output logic lane_write_enable_n,
    output logic [PBSP_LANES-1:0] lane_write_select_n,
    output logic chip_select_first_n,
    output logic chip_select_second,
    output logic chip_select_third_n,
    output logic [PBSP_DATA_W-1:0] dq_in,
    output logic [PBSP_LANES-1:0] data_parity_lines_in,
    output logic rd_mark
);
    timeunit 1ns;
    timeprecision 1ns;

    initial begin
        {processor_addr_strobe_n, controller_addr_strobe_n, burst_advance_n} = 3'h7;
        {all_bytes_write_n, lane_write_enable_n, lane_write_select_n} = 6'h3F;
        {chip_select_first_n, chip_select_second, chip_select_third_n} = 3'h2;
        address = '0;
        {data_parity_lines_in, dq_in} = '0;
        rd_mark = 1'b0;
    end

    // ctl = {proc strobe, ctrl strobe, advance, global write, lane enable}, all active low
    task automatic put(input logic [4:0] ctl, input logic [3:0] lanes_n, input logic [2:0] sel,
                       input logic [AW-1:0] a, input pbsp_word_t wd, input logic rd);
        @(posedge mclk);
        {processor_addr_strobe_n, controller_addr_strobe_n, burst_advance_n} <= ctl[4:2];
        {all_bytes_write_n, lane_write_enable_n} <= ctl[1:0];
        lane_write_select_n <= lanes_n;
        {chip_select_first_n, chip_select_second, chip_select_third_n} <= sel;
        address <= a;
        rd_mark <= rd;
        // Released lines toggle so a stale word never passes for fresh data
        if (!ctl[1] || !ctl[0])
            {data_parity_lines_in, dq_in} <= wd;
        else
            {data_parity_lines_in, dq_in} <= ~{data_parity_lines_in, dq_in};
    endtask

    task automatic idle(input int n);
        repeat (n) put(5'h1F, 4'hF, 3'h2, address, '0, 1'b0);
    endtask
endmodule

/* bench/pbsp_port_tb_top.sv */
/*
 Self-checking bench of the burst memory port with a queue of expected reads.
 Assumes the port is built with a 4-bit address and three chip selects.
*/
module pbsp_port_tb_top
    import pbsp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [2:0] SEL = 3'h2;
    // Deselecting patterns: first high, second low, third high
    localparam logic [2:0] SEL_BAD [3] = '{3'h6, 3'h0, 3'h3};
    logic mclk = 1'b0;
    logic rstn, oe_n, sleep, strap, sleeping, dq_oe, par_oe;
    logic rd_mark_d = 1'b0;
    logic [3:0] last_a, a;
    logic [15:0] rnd = 16'h02F6;
    wire logic ps_n, cs_n, adv_n, gw_n, bwe_n, ce1_n, ce2, ce3_n, rd_mark;
    wire logic [3:0] bws_n, addr, par_in;
    logic [3:0] par_out;
    wire logic [31:0] dq_in;
    logic [31:0] dq_out;
    pbsp_word_t exp_mem [16];
    pbsp_word_t exp_q [$];
    int n_errors = 0;
    int comparisons = 0;
    int cycles = 0;

    pbsp_ctrl_model #(.AW(4)) u_pbsp_ctrl_model (.mclk(mclk), .address(addr),
        .processor_addr_strobe_n(ps_n), .controller_addr_strobe_n(cs_n),
        .burst_advance_n(adv_n), .all_bytes_write_n(gw_n), .lane_write_enable_n(bwe_n),
        .lane_write_select_n(bws_n), .chip_select_first_n(ce1_n), .chip_select_second(ce2),
        .chip_select_third_n(ce3_n), .dq_in(dq_in), .data_parity_lines_in(par_in),
        .rd_mark(rd_mark));

    pbsp_port #(.ADDR_W(4), .HAS_THIRD_SELECT(1'b1)) u_pbsp_port (.mclk(mclk), .rstn(rstn),
        .address(addr), .processor_addr_strobe_n(ps_n), .controller_addr_strobe_n(cs_n),
        .burst_advance_n(adv_n), .all_bytes_write_n(gw_n), .lane_write_enable_n(bwe_n),
        .lane_write_select_n(bws_n), .chip_select_first_n(ce1_n), .chip_select_second(ce2),
        .chip_select_third_n(ce3_n), .output_enable_n(oe_n), .sleep_request(sleep),
        .burst_order_strap(strap), .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe),
        .data_parity_lines_in(par_in), .data_parity_lines_out(par_out),
        .data_parity_lines_oe(par_oe), .sleeping(sleeping));

    always #50 mclk = ~mclk;

    function automatic pbsp_word_t rword();
        rnd = {rnd[14:0], rnd[15] ^ rnd[13] ^ rnd[12] ^ rnd[10]};
        return {rnd[3:0], rnd, rnd ^ 16'hA5C3};
    endfunction

    task automatic check(input logic [35:0] seen, input logic [35:0] want);
        comparisons++;
        if (seen !== want) begin
            n_errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask

    task automatic report_and_stop();
        $display("comparisons %0d, mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic wr(input logic [3:0] wa, input logic g_n, input logic e_n, input logic [3:0] s_n);
        pbsp_word_t d;
        d = rword();
        u_pbsp_ctrl_model.put({3'h5, g_n, e_n}, s_n, SEL, wa, d, 1'b0);
        for (int i = 0; i < 4; i++) begin
            if (!g_n || (!e_n && !s_n[i])) begin
                exp_mem[wa][8*i +: 8] = d[8*i +: 8];
                exp_mem[wa][32+i] = d[32+i];
            end
        end
    endtask

    // Continuation cycles present the select pattern rnd[2:0] ^ k, which must be ignored
    task automatic rd(input logic [3:0] ra, input int n);
        u_pbsp_ctrl_model.put(5'h0F, 4'hF, SEL, ra, '0, 1'b1);
        exp_q.push_back(exp_mem[ra]);
        last_a = ra;
        for (int k = 1; k <= n; k++) begin
            u_pbsp_ctrl_model.put(5'h1B, 4'hF, rnd[2:0] ^ 3'(k), ra, '0, 1'b1);
            last_a = {ra[3:2], strap ? ra[1:0] ^ 2'(k) : ra[1:0] + 2'(k)};
            exp_q.push_back(exp_mem[last_a]);
        end
    endtask

    always @(posedge mclk) begin
        rd_mark_d <= rd_mark;
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            n_errors++;
            report_and_stop();
        end
    end

    always @(negedge mclk) begin
        if (rd_mark_d && rstn) begin
            check({par_out, dq_out}, exp_q.pop_front());
            check(36'({par_oe, dq_oe}), 36'({~oe_n, ~oe_n}));
        end
    end

    initial begin
        rstn = 1'b0;
        oe_n = 1'b0;
        sleep = 1'b0;
        strap = 1'b0;
        for (int s = 0; s < 2; s++) begin
            rstn <= 1'b0;
            strap <= s[0];
            u_pbsp_ctrl_model.idle(2);
            rstn <= 1'b1;
            u_pbsp_ctrl_model.idle(3);
            for (int i = 0; i < 16; i++) wr(4'(i), 1'b0, 1'b1, 4'hF);
            repeat (12) wr(rnd[3:0], 1'b1, rnd[5], rnd[9:6]);
            for (int b = 0; b < 4; b++) begin
                oe_n <= rnd[8 + b];
                rd(rnd[7:4] + 4'(b), 3);
            end
            oe_n <= 1'b0;
            // Processor strobe with first select high falls through to a held burst
            u_pbsp_ctrl_model.put(5'h0F, 4'hF, 3'h6, rnd[3:0], '0, 1'b1);
            exp_q.push_back(exp_mem[last_a]);
            a = rnd[11:8];
            u_pbsp_ctrl_model.put(5'h04, 4'h0, SEL, a, rword(), 1'b1);
            exp_q.push_back(exp_mem[a]);
            rd(a, 0);
            foreach (SEL_BAD[j]) u_pbsp_ctrl_model.put({3'h5, rnd[1:0]}, rnd[5:2], SEL_BAD[j], a,
                                                       rword(), 1'b0);
            u_pbsp_ctrl_model.idle(2);
            u_pbsp_ctrl_model.put(5'h0F, 4'hF, 3'h6, a, '0, 1'b0);
            @(negedge mclk);
            check(36'(dq_oe), 36'h0);
            rd(a, 1);
            sleep <= 1'b1;
            u_pbsp_ctrl_model.idle(5);
            @(negedge mclk);
            check(36'(sleeping), 36'h1);
            u_pbsp_ctrl_model.put(5'h15, 4'hF, SEL, a, rword(), 1'b0);
            sleep <= 1'b0;
            u_pbsp_ctrl_model.idle(5);
            @(negedge mclk);
            check(36'(sleeping), 36'h0);
            rd(a, 0);
            // Let the last read be compared before the next reset cuts it
            u_pbsp_ctrl_model.idle(2);
        end
        u_pbsp_ctrl_model.idle(3);
        check(36'(exp_q.size()), 36'h0);
        report_and_stop();
    end
endmodule
